// *** inc/usb_port_map.svh ***
// Register offsets, field positions, codes and sizes of the USB device port.
// Definitions only; included by bare name from the design files.
`ifndef USB_PORT_MAP_SVH
`define USB_PORT_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the 8-bit register port)
// ----------------------------------------------------------------------
`define EPR_CSR_ADDR 8'h00
`define EPR_FIFO_ADDR 8'h04
`define EPR_COUNT_ADDR 8'h08
`define EPR_INTEN_ADDR 8'h0C
`define EPR_WAKE_ADDR 8'h10
`define EPR_XCVR_ADDR 8'h14

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define EPR_CSR_TXCOMP 0
`define EPR_CSR_RXDATA 1
`define EPR_CSR_SETUP 2
`define EPR_CSR_STALL 3
`define EPR_CSR_TXRDY 4
`define EPR_CSR_DIR 7
`define EPR_WAKE_EN 0
`define EPR_WAKE_SUSP 1
`define EPR_WAKE_REQ 2
`define EPR_XCVR_OFF 0
`define EPR_BYTE_RESET 8'h00

// ----------------------------------------------------------------------
// Link event lanes, answer codes and endpoint size
// ----------------------------------------------------------------------
`define EPR_SY_BYTE 0
`define EPR_SY_START 1
`define EPR_SY_END 2
`define EPR_SY_IN 3
`define EPR_SY_INACK 4
`define EPR_SY_POP 5
`define EPR_SY_SUSP 6
`define EPR_SY_RESUME 7
`define EPR_SY_LANES 8
`define EPR_HS_ACK 2'h0
`define EPR_HS_NAK 2'h1
`define EPR_HS_STALL 2'h2
`define EPR_HS_DATA 2'h3
`define EPR_EP0_SIZE 8
`define EPR_SETUP_LEN 8

`endif

// *** inc/usb_port_pkg.sv ***
// Types shared by the USB device port design.
// Assumes nothing of its surroundings.
package usb_port_pkg;

   // Control transfer stage of endpoint zero
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DATA_IN,
      ST_DATA_OUT,
      ST_STATUS_IN
   } ctl_stage_t;

endpackage

// *** rtl/sync_toggle.sv ***
// Two-flop synchroniser bank with change detection per lane.
// Assumes each lane is a level or a toggle from another clock domain.
`timescale 1ns/1ns
`default_nettype none

module sync_toggle #(
   parameter int N = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [N-1:0] d_i,
   output logic [N-1:0] level_o,
   output logic [N-1:0] pulse_o
);

   logic [N-1:0] meta;
   logic [N-1:0] sync;
   logic [N-1:0] last;

   // First stage feeds only the second; edge logic looks at later stages
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         sync <= '0;
         last <= '0;
      end else begin
         meta <= d_i;
         sync <= meta;
         last <= sync;
      end
   end

   // Any change of the settled level is one event
   assign level_o = sync;
   assign pulse_o = sync ^ last;

endmodule

`default_nettype wire

// *** rtl/usb_device_port.sv ***
// USB full-speed device port: endpoint zero control logic and byte-wide registers.
// Assumes a serial interface engine on the 48 MHz clock reports packet events as
// toggles with bundled data, and a processor on the register port at clk_i.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "usb_port_map.svh"

module usb_device_port #(
   parameter int EP_SIZE = `EPR_EP0_SIZE
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic irq_o,
   input wire logic [7:0] rx_byte_i,
   input wire logic rx_byte_tog_i,
   input wire logic rx_start_tog_i,
   input wire logic rx_setup_i,
   input wire logic rx_end_tog_i,
   input wire logic in_tok_tog_i,
   input wire logic in_ack_tog_i,
   input wire logic tx_pop_tog_i,
   input wire logic suspend_i,
   input wire logic external_resume_i,
   output logic hs_tog_o,
   output logic [1:0] hs_code_o,
   output logic [7:0] tx_len_o,
   output logic [7:0] tx_data_o,
   output logic tx_data1_o,
   output logic resume_req_o,
   output logic xcvr_off_o
);

   localparam int IW = $clog2(EP_SIZE);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic valid_size(input int s);
      return (s == 8) || (s == 16) || (s == 32) || (s == 64);
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // ----------------------------------------------------------------------
   // Link event crossing
   // ----------------------------------------------------------------------
   logic [`EPR_SY_LANES-1:0] sy_lvl;
   logic [`EPR_SY_LANES-1:0] sy_pls;
   logic byte_p, start_p, end_p, in_p, inack_p, pop_p, susp, resume_p;
   logic [8:0] rx_dat;

   // Packet events are toggles so none is lost across the clock boundary; suspend and resume are levels
   sync_toggle #(.N(`EPR_SY_LANES)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({external_resume_i, suspend_i, tx_pop_tog_i, in_ack_tog_i,
            in_tok_tog_i, rx_end_tog_i, rx_start_tog_i, rx_byte_tog_i}),
      .level_o(sy_lvl),
      .pulse_o(sy_pls)
   );

   // Bundled byte and packet kind pass the same two stages as their event and keep their lead on it
   sync_toggle #(.N(9)) u_sync_dat (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({rx_setup_i, rx_byte_i}),
      .level_o(rx_dat),
      .pulse_o()
   );

   assign byte_p = sy_pls[`EPR_SY_BYTE];
   assign start_p = sy_pls[`EPR_SY_START];
   assign end_p = sy_pls[`EPR_SY_END];
   assign in_p = sy_pls[`EPR_SY_IN];
   assign inack_p = sy_pls[`EPR_SY_INACK];
   assign pop_p = sy_pls[`EPR_SY_POP];
   assign susp = sy_lvl[`EPR_SY_SUSP];
   assign resume_p = sy_pls[`EPR_SY_RESUME] & sy_lvl[`EPR_SY_RESUME];

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [7:0] fifo [EP_SIZE];
   logic [IW-1:0] link_idx, cpu_idx, tx_idx;
   logic [IW:0] rx_count, cpu_count;
   logic pkt_setup, pkt_accept;
   logic setup_flag, rxdata, txcomp, txpktrdy, force_stall, dir_in, data1;
   logic int_en, wake_en;
   usb_port_pkg::ctl_stage_t stage;
   logic csr_wr, fifo_wr, fifo_rd, can_take;
   logic setup_done, out_ok, in_send, wlen_zero;

   assign csr_wr = reg_wr_i && hit(reg_addr_i, `EPR_CSR_ADDR);
   assign fifo_wr = reg_wr_i && hit(reg_addr_i, `EPR_FIFO_ADDR);
   assign fifo_rd = reg_rd_i && hit(reg_addr_i, `EPR_FIFO_ADDR);
   // Busy endpoint refuses OUT data so unread bytes survive
   assign can_take = !setup_flag && !rxdata && !force_stall;
   assign setup_done = end_p && pkt_setup;
   assign out_ok = end_p && !pkt_setup && !force_stall && pkt_accept;
   assign in_send = in_p && !end_p && !force_stall && txpktrdy;
   assign wlen_zero = (fifo[6] == `EPR_BYTE_RESET) && (fifo[7] == `EPR_BYTE_RESET);

   // Packet kind latched at start; setup is always taken
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pkt_setup <= 1'b0;
         pkt_accept <= 1'b0;
      end else if (start_p) begin
         pkt_setup <= rx_dat[8];
         pkt_accept <= rx_dat[8] || can_take;
      end
   end

   // Single bank shared by link and processor
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < EP_SIZE; i++) begin
            fifo[i] <= `EPR_BYTE_RESET;
         end
      end else if (byte_p && pkt_accept && (rx_count < (IW+1)'(EP_SIZE))) begin
         fifo[link_idx] <= rx_dat[7:0];
      end else if (fifo_wr) begin
         fifo[cpu_idx] <= reg_wdata_i;
      end
   end

   // Link receive pointer and byte count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_idx <= '0;
         rx_count <= '0;
      end else if (start_p && (rx_dat[8] || can_take)) begin
         link_idx <= '0;
         rx_count <= '0;
      end else if (byte_p && pkt_accept && (rx_count < (IW+1)'(EP_SIZE))) begin
         link_idx <= link_idx + 1'b1;
         rx_count <= rx_count + 1'b1;
      end
   end

   // Processor pointer; rewinds on each accepted setup or OUT packet, on acked IN and on status writes, except the
   // one that hands a packet over, so the written byte count survives to the IN
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_idx <= '0;
         cpu_count <= '0;
      end else if (setup_done || out_ok || inack_p ||
                   (csr_wr && !reg_wdata_i[`EPR_CSR_TXRDY])) begin
         cpu_idx <= '0;
         cpu_count <= '0;
      end else if (fifo_rd || fifo_wr) begin
         cpu_idx <= cpu_idx + 1'b1;
         cpu_count <= (cpu_count < (IW+1)'(EP_SIZE)) ? cpu_count + 1'b1 : cpu_count;
      end
   end

   // Transmit pointer restarts at every IN token
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_idx <= '0;
         tx_data_o <= `EPR_BYTE_RESET;
      end else begin
         tx_data_o <= fifo[tx_idx];
         if (in_p) begin
            tx_idx <= '0;
         end else if (pop_p) begin
            tx_idx <= tx_idx + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Endpoint flags: hardware set wins over a same-cycle software clear
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         setup_flag <= 1'b0;
      end else if (setup_done) begin
         setup_flag <= 1'b1;
      end else if (csr_wr && !reg_wdata_i[`EPR_CSR_SETUP]) begin
         setup_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rxdata <= 1'b0;
      end else if (out_ok) begin
         rxdata <= 1'b1;
      end else if (csr_wr && !reg_wdata_i[`EPR_CSR_RXDATA]) begin
         rxdata <= 1'b0;
      end
   end

   // Acked IN ends the bank hand-over
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         txcomp <= 1'b0;
         txpktrdy <= 1'b0;
      end else begin
         if (inack_p) begin
            txcomp <= 1'b1;
         end else if (csr_wr && !reg_wdata_i[`EPR_CSR_TXCOMP]) begin
            txcomp <= 1'b0;
         end
         if (inack_p || setup_done) begin
            txpktrdy <= 1'b0;
         end else if (csr_wr && reg_wdata_i[`EPR_CSR_TXRDY]) begin
            txpktrdy <= 1'b1;
         end
      end
   end

   // Stall request stands until software drops it or a new setup arrives
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         force_stall <= 1'b0;
      end else if (setup_done) begin
         force_stall <= 1'b0;
      end else if (csr_wr) begin
         force_stall <= reg_wdata_i[`EPR_CSR_STALL];
      end
   end

   // ----------------------------------------------------------------------
   // Control transfer stages of endpoint zero
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stage <= usb_port_pkg::ST_IDLE;
         dir_in <= 1'b0;
      end else if (setup_done) begin
         dir_in <= fifo[0][7];
         if (fifo[0][7]) begin
            stage <= usb_port_pkg::ST_DATA_IN;
         end else if (wlen_zero) begin
            stage <= usb_port_pkg::ST_STATUS_IN;
         end else begin
            stage <= usb_port_pkg::ST_DATA_OUT;
         end
      end else begin
         case (stage)
            usb_port_pkg::ST_DATA_OUT: begin
               if (in_p) begin
                  stage <= usb_port_pkg::ST_STATUS_IN;
               end
            end
            usb_port_pkg::ST_DATA_IN: begin
               if (out_ok) begin
                  stage <= usb_port_pkg::ST_IDLE;
               end
            end
            usb_port_pkg::ST_STATUS_IN: begin
               if (inack_p) begin
                  stage <= usb_port_pkg::ST_IDLE;
               end
            end
            default: begin
               stage <= usb_port_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Data toggle: first data stage packet after setup is DATA1
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data1 <= 1'b0;
      end else if (setup_done) begin
         data1 <= 1'b1;
      end else if (out_ok || inack_p) begin
         data1 <= !data1;
      end
   end

   // ----------------------------------------------------------------------
   // Answers to the engine; the engine alone drives the bus lines
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hs_tog_o <= 1'b0;
         hs_code_o <= `EPR_HS_NAK;
         tx_len_o <= `EPR_BYTE_RESET;
         tx_data1_o <= 1'b0;
      end else if (end_p || in_p) begin
         hs_tog_o <= !hs_tog_o;
         if (setup_done || out_ok) begin
            hs_code_o <= `EPR_HS_ACK;
         end else if (force_stall) begin
            hs_code_o <= `EPR_HS_STALL;
         end else if (in_send) begin
            hs_code_o <= `EPR_HS_DATA;
            tx_len_o <= 8'(cpu_count);
            // Status IN is always DATA1, empty when software wrote no bytes
            tx_data1_o <= (stage == usb_port_pkg::ST_DATA_OUT) ||
                          (stage == usb_port_pkg::ST_STATUS_IN) || data1;
         end else begin
            hs_code_o <= `EPR_HS_NAK;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Wake, transceiver and interrupt control
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         int_en <= 1'b0;
         wake_en <= 1'b0;
         xcvr_off_o <= 1'b0;
      end else if (reg_wr_i) begin
         if (hit(reg_addr_i, `EPR_INTEN_ADDR)) begin
            int_en <= reg_wdata_i[0];
         end else if (hit(reg_addr_i, `EPR_WAKE_ADDR)) begin
            wake_en <= reg_wdata_i[`EPR_WAKE_EN];
         end else if (hit(reg_addr_i, `EPR_XCVR_ADDR)) begin
            xcvr_off_o <= reg_wdata_i[`EPR_XCVR_OFF];
         end
      end
   end

   // Request held until the host ends the suspend
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         resume_req_o <= 1'b0;
      end else if (!susp) begin
         resume_req_o <= 1'b0;
      end else if (resume_p && wake_en) begin
         resume_req_o <= 1'b1;
      end
   end

   assign irq_o = int_en && (setup_flag || rxdata || txcomp);

   // ----------------------------------------------------------------------
   // Register read port: data valid only in the cycle after the strobe
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= `EPR_BYTE_RESET;
      end else if (!reg_rd_i) begin
         reg_rdata_o <= `EPR_BYTE_RESET;
      end else if (hit(reg_addr_i, `EPR_CSR_ADDR)) begin
         reg_rdata_o <= {dir_in, 2'b00, txpktrdy, force_stall, setup_flag, rxdata, txcomp};
      end else if (hit(reg_addr_i, `EPR_FIFO_ADDR)) begin
         reg_rdata_o <= fifo[cpu_idx];
      end else if (hit(reg_addr_i, `EPR_COUNT_ADDR)) begin
         reg_rdata_o <= 8'(rx_count);
      end else if (hit(reg_addr_i, `EPR_INTEN_ADDR)) begin
         reg_rdata_o <= {7'h00, int_en};
      end else if (hit(reg_addr_i, `EPR_WAKE_ADDR)) begin
         reg_rdata_o <= {5'h00, resume_req_o, susp, wake_en};
      end else if (hit(reg_addr_i, `EPR_XCVR_ADDR)) begin
         reg_rdata_o <= {7'h00, xcvr_off_o};
      end else begin
         reg_rdata_o <= `EPR_BYTE_RESET;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence setup_arrives;
      end_p && pkt_setup;
   endsequence

   sequence sleeping_wake;
      susp && wake_en && resume_p;
   endsequence

   chk_size_legal: assert property (valid_size(EP_SIZE))
      else $error("endpoint size not 8, 16, 32 or 64");
   chk_setup_flag: assert property (setup_arrives |=> setup_flag ##0 irq_o == int_en)
      else $error("setup flag or interrupt wrong after setup");
   chk_setup_ack: assert property (setup_arrives
      |=> hs_code_o == `EPR_HS_ACK && $changed(hs_tog_o))
      else $error("setup not acknowledged");
   chk_stall_answer: assert property (in_p && force_stall |=> hs_code_o == `EPR_HS_STALL)
      else $error("stall request not answered");
   chk_status_data1: assert property (in_send && stage == usb_port_pkg::ST_STATUS_IN
      |=> tx_data1_o)
      else $error("status IN not DATA1");
   chk_status_entry: assert property ($changed(stage) && stage == usb_port_pkg::ST_STATUS_IN
      |-> $past(setup_done) || $past(stage) == usb_port_pkg::ST_DATA_OUT)
      else $error("status stage entered out of order");
   chk_flag_on_read: assert property (setup_flag && fifo_rd && !csr_wr
      |=> setup_flag ##1 (setup_flag || $past(csr_wr)))
      else $error("setup flag lost on FIFO read");
   chk_read_timing: assert property (reg_rd_i && hit(reg_addr_i, `EPR_COUNT_ADDR)
      |=> reg_rdata_o == 8'($past(rx_count))
      ##1 ($past(reg_rd_i) || reg_rdata_o == `EPR_BYTE_RESET))
      else $error("read data not in the following cycle only");
   chk_resume_req: assert property (sleeping_wake |=> resume_req_o)
      else $error("remote wake not requested");

endmodule

`default_nettype wire

// *** verif/usb_device_port_tb.sv ***
// Self-checking bench for the USB device port, endpoint zero only.
// Assumes the port is driven by usb_host_model on its link side.
`timescale 1ns/1ns
`default_nettype none
`include "usb_port_map.svh"

module usb_device_port_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic suspend = 1'b0;
   logic ext_res = 1'b0;
   logic [7:0] rdata, tx_len, rx_byte, tog, v, tx_data;
   logic [1:0] hs_code;
   logic irq, hs_tog, tx_d1, res_req, xoff, rx_setup, h0;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;

   // -------------------------------------------------------------
   // Clock, instances, watchdog
   // -------------------------------------------------------------
   always #25 clk = ~clk;

   usb_host_model i_usb_host_model (.clk_i(clk), .rx_byte_o(rx_byte),
      .rx_setup_o(rx_setup), .tog_o(tog));

   usb_device_port i_usb_device_port (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .irq_o(irq), .rx_byte_i(rx_byte), .rx_byte_tog_i(tog[`EPR_SY_BYTE]),
      .rx_start_tog_i(tog[`EPR_SY_START]), .rx_setup_i(rx_setup),
      .rx_end_tog_i(tog[`EPR_SY_END]), .in_tok_tog_i(tog[`EPR_SY_IN]),
      .in_ack_tog_i(tog[`EPR_SY_INACK]), .tx_pop_tog_i(tog[`EPR_SY_POP]),
      .suspend_i(suspend), .external_resume_i(ext_res), .hs_tog_o(hs_tog),
      .hs_code_o(hs_code), .tx_len_o(tx_len), .tx_data_o(tx_data), .tx_data1_o(tx_d1),
      .resume_req_o(res_req), .xcvr_off_o(xoff));

   // Cuts a hang short; the whole run needs far fewer cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         summarize();
      end
   end

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Answer must flip the handshake toggle and carry the given code
   task automatic ans(input logic [1:0] code);
      chk("hs_tog", {7'h0, ~h0}, {7'h0, hs_tog});
      chk("hs_code", {6'h0, code}, {6'h0, hs_code});
   endtask

   task automatic summarize();
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   // Setup is taken, stored and flagged without any register access
   task automatic t_setup();
      h0 = hs_tog;
      i_usb_host_model.packet(1'b1, 64'h0000000000120500, 8);
      ans(`EPR_HS_ACK);
      rd_reg(`EPR_CSR_ADDR, v);
      chk("setup flag", 8'h04, v & 8'h04);
      rd_reg(`EPR_COUNT_ADDR, v);
      chk("rx count", 8'h08, v);
      chk("irq masked", 8'h00, {7'h0, irq});
      wr_reg(`EPR_INTEN_ADDR, 8'h01);
      #1 chk("irq on", 8'h01, {7'h0, irq});
      for (int i = 0; i < 8; i++) begin
         rd_reg(`EPR_FIFO_ADDR, v);
         chk("fifo byte", 8'(64'h0000000000120500 >> (8*i)), v);
      end
      rd_reg(`EPR_CSR_ADDR, v);
      chk("flag kept", 8'h04, v & 8'h04);
      wr_reg(`EPR_CSR_ADDR, 8'h00);
      rd_reg(`EPR_CSR_ADDR, v);
      chk("flag cleared", 8'h00, v & 8'h04);
      chk("irq off", 8'h00, {7'h0, irq});
   endtask

   // No-data control write closes with a zero-length DATA1 packet
   task automatic t_status_in();
      wr_reg(`EPR_CSR_ADDR, 8'h10);
      h0 = hs_tog;
      i_usb_host_model.flip(`EPR_SY_IN);
      ans(`EPR_HS_DATA);
      chk("zero length", 8'h00, tx_len);
      chk("data1 pid", 8'h01, {7'h0, tx_d1});
      i_usb_host_model.flip(`EPR_SY_INACK);
      rd_reg(`EPR_CSR_ADDR, v);
      chk("txcomp", 8'h01, v & 8'h11);
      chk("irq txcomp", 8'h01, {7'h0, irq});
      wr_reg(`EPR_CSR_ADDR, 8'h00);
   endtask

   // Control read: written bytes go out in the IN stage, host closes with empty OUT
   task automatic t_ctl_read();
      h0 = hs_tog;
      i_usb_host_model.packet(1'b1, 64'h0000000000000680, 8);
      ans(`EPR_HS_ACK);
      rd_reg(`EPR_CSR_ADDR, v);
      chk("dir in", 8'h84, v & 8'h84);
      for (int i = 0; i < 8; i++) begin
         rd_reg(`EPR_FIFO_ADDR, v);
      end
      wr_reg(`EPR_CSR_ADDR, 8'h00);
      wr_reg(`EPR_FIFO_ADDR, 8'hA5);
      wr_reg(`EPR_FIFO_ADDR, 8'h5A);
      wr_reg(`EPR_CSR_ADDR, 8'h10);
      h0 = hs_tog;
      i_usb_host_model.flip(`EPR_SY_IN);
      ans(`EPR_HS_DATA);
      chk("in length", 8'h02, tx_len);
      chk("in data1", 8'h01, {7'h0, tx_d1});
      chk("tx byte 0", 8'hA5, tx_data);
      i_usb_host_model.flip(`EPR_SY_POP);
      chk("tx byte 1", 8'h5A, tx_data);
      i_usb_host_model.flip(`EPR_SY_INACK);
      h0 = hs_tog;
      i_usb_host_model.packet(1'b0, 64'h0, 0);
      ans(`EPR_HS_ACK);
      rd_reg(`EPR_CSR_ADDR, v);
      chk("status out", 8'h83, v);
      wr_reg(`EPR_CSR_ADDR, 8'h00);
   endtask

   // Forced stall answers IN and refuses OUT data alike
   task automatic t_stall();
      wr_reg(`EPR_CSR_ADDR, 8'h08);
      h0 = hs_tog;
      i_usb_host_model.flip(`EPR_SY_IN);
      ans(`EPR_HS_STALL);
      h0 = hs_tog;
      i_usb_host_model.packet(1'b0, 64'h0, 0);
      ans(`EPR_HS_STALL);
      rd_reg(8'h20, v);
      chk("unmapped", 8'h00, v);
   endtask

   // Remote wake while suspended, then transceiver switched off
   task automatic t_wake();
      @(posedge clk);
      suspend <= 1'b1;
      wr_reg(`EPR_WAKE_ADDR, 8'h01);
      ext_res <= 1'b1;
      repeat (8) @(posedge clk);
      chk("resume req", 8'h01, {7'h0, res_req});
      rd_reg(`EPR_WAKE_ADDR, v);
      chk("wake reg", 8'h07, v & 8'h07);
      wr_reg(`EPR_XCVR_ADDR, 8'h01);
      #1 chk("xcvr off", 8'h01, {7'h0, xoff});
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk("reset hs", {6'h0, `EPR_HS_NAK}, {6'h0, hs_code});
      t_setup();
      t_status_in();
      t_ctl_read();
      t_stall();
      t_wake();
      summarize();
   end
endmodule

`default_nettype wire

// *** verif/usb_host_model.sv ***
// Partner model: host and serial engine side of the link, as event toggles.
// Assumes the bench calls its tasks and that it shares clk_i with the port.
`timescale 1ns/1ns
`default_nettype none
`include "usb_port_map.svh"

module usb_host_model (
   input wire logic clk_i,
   output logic [7:0] rx_byte_o,
   output logic rx_setup_o,
   output logic [7:0] tog_o
);
   // -------------------------------------------------------------
   // Event lanes
   // -------------------------------------------------------------
   // All lanes rest at zero through reset, as the port expects
   initial begin
      rx_byte_o = 8'h00;
      // Pullup and bus sensing stay on the board; the host counts as attached and powered
      rx_setup_o = 1'b0;
      tog_o = 8'h00;
   end

   // One event, then a gap well above the minimum toggle spacing
   task automatic flip(input int k);
      @(posedge clk_i);
      tog_o[k] <= ~tog_o[k];
      repeat (6) @(posedge clk_i);
   endtask

   // Whole packet in order; the byte line is scrambled once used up,
   // so a port that samples late never sees a lucky stale value
   task automatic packet(input logic setup, input logic [63:0] d, input int n);
      @(posedge clk_i);
      rx_setup_o <= setup;
      flip(`EPR_SY_START);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         rx_byte_o <= d[8*i +: 8];
         flip(`EPR_SY_BYTE);
         rx_byte_o <= ~d[8*i +: 8];
      end
      flip(`EPR_SY_END);
      rx_setup_o <= 1'b0;
   endtask
endmodule

`default_nettype wire
